// ---- ccr_core_model.sv ----
/* ccr_core_model: analog comparator core and timer-one clock source.
   Assumes aclk paces both; the bench sets the input levels. */
`timescale 1ns/1ps
module ccr_core_model
   import ccr_pkg::*;
(
   // clock
   input  wire logic        aclk,
   // analog side
   input  wire logic [7:0]  positive_input,
   input  wire logic [7:0]  negative_input,
   input  wire ccr_analog_s analog_ctrl,
   output logic             raw_compare,
   output logic             timer_one_clk
);
   initial begin
      raw_compare = 1'b0;
      timer_one_clk = 1'b1;
   end
   // inputs switched off give no valid decision
   always @(posedge aclk) begin
      if (analog_ctrl.inputs_enable) raw_compare <= positive_input > negative_input;
      else raw_compare <= ~raw_compare;
   end
   // timer clock stands high outside a requested low phase
   task fall;
      @(posedge aclk);
      timer_one_clk <= 1'b0;
      repeat (2) @(posedge aclk);
      timer_one_clk <= 1'b1;
   endtask : fall
endmodule : ccr_core_model

// ---- ccr_pkg.sv ----
/*
 * ccr_pkg: constants and carrier types for the comparator control register block.
 * Assumes a 32-bit AXI4-Lite register bus and an 8-bit control register.
 */
package ccr_pkg;
   localparam int          CCR_AW          = 4;
   localparam logic [3:0]  CCR_OFF_CTRL    = 4'h0;
   localparam logic [3:0]  CCR_OFF_STATUS  = 4'h4;
   // control register field positions
   localparam int          CCR_B_ENABLE    = 7;
   localparam int          CCR_B_RESULT    = 6;
   localparam int          CCR_B_PIN_EN    = 5;
   localparam int          CCR_B_INVERT    = 4;
   localparam int          CCR_B_UNUSED    = 3;
   localparam int          CCR_B_SPEED     = 2;
   localparam int          CCR_B_HYST      = 1;
   localparam int          CCR_B_SYNC      = 0;
   localparam logic [7:0]  CCR_WR_MASK     = 8'hB7;
   localparam logic [7:0]  CCR_CTRL_RESET  = 8'h04;
   localparam logic [1:0]  CCR_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  CCR_RESP_SLVERR = 2'h2;

   // settings driven to the analog core
   typedef struct packed {
      logic enable;
      logic speed_power_select;
      logic hysteresis_enable;
      logic inputs_enable;
   } ccr_analog_s;
endpackage : ccr_pkg

// ---- ccr_top.sv ----
/*
 * ccr_top: comparator control register with AXI4-Lite slave, polarity,
 * pin drive gating and timer-one synchronised result.
 * Assumes the raw comparator and timer-one clock inputs are synchronous to aclk.
 */
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ccr_top
   import ccr_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write
   input  wire logic [CCR_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [CCR_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // analog core and pin
   input  wire logic              raw_compare,
   input  wire logic              pin_direction_latch,
   input  wire logic              timer_one_clk,
   output ccr_analog_s            analog_ctrl,
   output logic                   result_pin_out,
   output logic                   result_pin_oe,
   output logic                   timer_one_result
);
   logic [7:0]        ctrl_r, ctrl_nxt;
   logic              aw_held_r, aw_held_nxt;
   logic              w_held_r, w_held_nxt;
   logic [CCR_AW-1:0] awaddr_r, awaddr_nxt;
   logic [31:0]       wdata_r, wdata_nxt;
   logic              wstrb0_r, wstrb0_nxt;
   logic              bvalid_r, bvalid_nxt;
   logic [1:0]        bresp_r, bresp_nxt;
   logic              rvalid_r, rvalid_nxt;
   logic [1:0]        rresp_r, rresp_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic              result_r, result_nxt;
   logic              tclk_r, tclk_nxt;
   logic              synced_r, synced_nxt;
   logic              pin_out_r, pin_out_nxt;
   logic              comp_level;
   logic              do_write;
   logic [7:0]        ctrl_view;

   // polarity applied to the comparator decision
   assign comp_level = ctrl_r[CCR_B_ENABLE] &
                       (raw_compare ^ ctrl_r[CCR_B_INVERT]);
   assign ctrl_view  = {ctrl_r[7], result_r, ctrl_r[5:4], 1'b0, ctrl_r[2:0]};

   assign s_axi_awready = ~aw_held_r & ~bvalid_r;
   assign s_axi_wready  = ~w_held_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign do_write      = (aw_held_r | s_axi_awvalid) & (w_held_r | s_axi_wvalid) & ~bvalid_r;

   always_comb begin
      logic [CCR_AW-1:0] wa;
      logic [31:0]       wd;
      logic              ws;
      wa          = aw_held_r ? awaddr_r : s_axi_awaddr;
      wd          = w_held_r ? wdata_r : s_axi_wdata;
      ws          = w_held_r ? wstrb0_r : s_axi_wstrb[0];
      ctrl_nxt    = ctrl_r;
      aw_held_nxt = aw_held_r;
      w_held_nxt  = w_held_r;
      awaddr_nxt  = awaddr_r;
      wdata_nxt   = wdata_r;
      wstrb0_nxt  = wstrb0_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_nxt = 1'b1;
         wdata_nxt  = s_axi_wdata;
         wstrb0_nxt = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = CCR_RESP_OKAY;
         if (wa == CCR_OFF_CTRL) begin
            if (ws) begin
               // only writable fields change
               ctrl_nxt = (ctrl_r & ~CCR_WR_MASK) | (wd[7:0] & CCR_WR_MASK);
            end
         end else if (wa != CCR_OFF_STATUS) begin
            bresp_nxt = CCR_RESP_SLVERR;
         end
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
   end

   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = CCR_RESP_OKAY;
         case (s_axi_araddr)
            CCR_OFF_CTRL:   rdata_nxt = {24'h000000, ctrl_view};
            CCR_OFF_STATUS: rdata_nxt = {29'h00000000, synced_r, comp_level, result_r};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = CCR_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // result sampled every clock; sync latch on timer-one falling edge
   always_comb begin
      result_nxt  = comp_level;
      tclk_nxt    = timer_one_clk;
      synced_nxt  = synced_r;
      if (tclk_r && !timer_one_clk) begin
         synced_nxt = comp_level;
      end
      pin_out_nxt = ctrl_r[CCR_B_SYNC] ? synced_r : result_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r    <= CCR_CTRL_RESET;
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= 32'h00000000;
         wstrb0_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= CCR_RESP_OKAY;
         rvalid_r  <= 1'b0;
         rresp_r   <= CCR_RESP_OKAY;
         rdata_r   <= 32'h00000000;
         result_r  <= 1'b0;
         tclk_r    <= 1'b0;
         synced_r  <= 1'b0;
         pin_out_r <= 1'b0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         aw_held_r <= aw_held_nxt;
         w_held_r  <= w_held_nxt;
         awaddr_r  <= awaddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb0_r  <= wstrb0_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
         result_r  <= result_nxt;
         tclk_r    <= tclk_nxt;
         synced_r  <= synced_nxt;
         pin_out_r <= pin_out_nxt;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp  = rresp_r;
   assign s_axi_rdata  = rdata_r;

   assign analog_ctrl.enable             = ctrl_r[CCR_B_ENABLE];
   assign analog_ctrl.speed_power_select = ctrl_r[CCR_B_SPEED];
   assign analog_ctrl.hysteresis_enable  = ctrl_r[CCR_B_HYST];
   assign analog_ctrl.inputs_enable      = ctrl_r[CCR_B_ENABLE];
   assign result_pin_oe    = ctrl_r[CCR_B_PIN_EN] & ~pin_direction_latch &
                             ctrl_r[CCR_B_ENABLE];
   assign result_pin_out   = pin_out_r;
   assign timer_one_result = pin_out_r;

   // checks
   a_result_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
      (ctrl_r[CCR_B_ENABLE] && !ctrl_r[CCR_B_INVERT] && $stable(ctrl_r))
      |=> result_r == $past(raw_compare))
      else $error("result does not follow comparator");
   a_result_invert: assert property (@(posedge aclk) disable iff (!aresetn)
      (ctrl_r[CCR_B_ENABLE] && ctrl_r[CCR_B_INVERT] && $stable(ctrl_r))
      |=> result_r == !$past(raw_compare))
      else $error("inverted result wrong");
   a_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_view[CCR_B_UNUSED] && !ctrl_r[CCR_B_UNUSED] && !ctrl_r[CCR_B_RESULT])
      else $error("unused or result bit stored");
   a_reset_value: assert property (@(posedge aclk)
      !aresetn |=> ctrl_r == CCR_CTRL_RESET)
      else $error("reset value wrong");
   a_sync_latch: assert property (@(posedge aclk) disable iff (!aresetn)
      (tclk_r && !timer_one_clk) |=> synced_r == $past(comp_level))
      else $error("sync latch missed falling edge");
   a_pin_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      result_pin_oe |-> ctrl_r[CCR_B_PIN_EN] && ctrl_r[CCR_B_ENABLE] && !pin_direction_latch)
      else $error("pin driven without enables");
   a_speed_default: assert property (@(posedge aclk)
      $rose(aresetn) |-> analog_ctrl.speed_power_select)
      else $error("speed not normal after reset");
   a_inputs_off: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_r[CCR_B_ENABLE] |-> !analog_ctrl.inputs_enable ##1 !result_r || ctrl_r[7])
      else $error("inputs active while disabled");
   a_write_fields: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && s_axi_awvalid && !aw_held_r && s_axi_awaddr == CCR_OFF_CTRL
       && s_axi_wvalid && !w_held_r && s_axi_wstrb[0])
      |=> ctrl_r == ($past(s_axi_wdata[7:0]) & CCR_WR_MASK))
      else $error("write did not update writable fields");
   c_write: cover property (@(posedge aclk) disable iff (!aresetn) do_write);
   c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
   c_pin: cover property (@(posedge aclk) disable iff (!aresetn) result_pin_oe);
   c_sync: cover property (@(posedge aclk) disable iff (!aresetn)
      ctrl_r[CCR_B_SYNC] && tclk_r && !timer_one_clk);
endmodule : ccr_top

// ---- tb.sv ----
/* tb: self-checking bench for ccr_top over AXI4-Lite.
   Assumes ccr_core_model stands in for the analog core and timer one. */
`timescale 1ns/1ps
module tb
   import ccr_pkg::*;
;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dir;
   logic        awready, wready, bvalid, arready, rvalid, raw, t1, pin, oe, t1r;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [7:0]  vp, vn;
   ccr_analog_s actl;
   int          n_errors, checks;
   localparam logic [1:0] OK = CCR_RESP_OKAY;
   ccr_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .raw_compare(raw), .pin_direction_latch(dir),
      .timer_one_clk(t1), .analog_ctrl(actl), .result_pin_out(pin),
      .result_pin_oe(oe), .timer_one_result(t1r));
   ccr_core_model PM (.aclk(aclk), .positive_input(vp), .negative_input(vn),
      .analog_ctrl(actl), .raw_compare(raw), .timer_one_clk(t1));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      while (!(ad && wd)) begin
         @(posedge aclk);
         ad |= (awready === 1'b1);
         wd |= (wready === 1'b1);
         {awvalid, wvalid} <= {~ad, ~wd};
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      chk("rdata", rdata, e);
      chk("rresp", {30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
   endtask : rc
   task automatic wc(input logic [7:0] d);
      logic [1:0] r;
      wr(CCR_OFF_CTRL, {24'h0, d}, r);
      chk("bresp", {30'h0, r}, {30'h0, OK});
      repeat (4) @(posedge aclk);
   endtask : wc
   task automatic t_reset;
      rc(CCR_OFF_CTRL, 32'h04, OK);
      chk("speed", {31'h0, actl.speed_power_select}, 32'h1);
      chk("inputs", {31'h0, actl.inputs_enable}, 32'h0);
      chk("oe", {31'h0, oe}, 32'h0);
      $display("reset test done");
   endtask : t_reset
   task automatic t_polarity;
      vp <= 8'h80;
      wc(8'hFF);
      rc(CCR_OFF_CTRL, 32'hB7, OK);
      vp <= 8'h10;
      wc(8'hFF);
      rc(CCR_OFF_CTRL, 32'hF7, OK);
      vp <= 8'h80;
      wc(8'h80);
      rc(CCR_OFF_CTRL, 32'hC0, OK);
      chk("speed", {31'h0, actl.speed_power_select}, 32'h0);
      chk("inputs", {31'h0, actl.inputs_enable}, 32'h1);
      vp <= 8'h20;
      wc(8'h80);
      rc(CCR_OFF_CTRL, 32'h80, OK);
      $display("polarity test done");
   endtask : t_polarity
   task automatic t_pin;
      vp <= 8'h80;
      wc(8'hA0);
      chk("oe", {31'h0, oe}, 32'h1);
      chk("pin", {31'h0, pin}, 32'h1);
      dir <= 1'b1;
      wc(8'hA0);
      chk("oe", {31'h0, oe}, 32'h0);
      dir <= 1'b0;
      wc(8'h20);
      chk("oe", {31'h0, oe}, 32'h0);
      chk("inputs", {31'h0, actl.inputs_enable}, 32'h0);
      rc(CCR_OFF_CTRL, 32'h20, OK);
      $display("pin test done");
   endtask : t_pin
   task automatic t_sync;
      logic [1:0] r;
      wc(8'h81);
      chk("sync", {31'h0, t1r}, 32'h0);
      PM.fall();
      repeat (4) @(posedge aclk);
      chk("sync", {31'h0, t1r}, 32'h1);
      vp <= 8'h20;
      wc(8'h81);
      chk("sync", {31'h0, t1r}, 32'h1);
      PM.fall();
      repeat (4) @(posedge aclk);
      chk("sync", {31'h0, t1r}, 32'h0);
      wr(4'h8, 32'hFF, r);
      chk("bresp", {30'h0, r}, {30'h0, CCR_RESP_SLVERR});
      rc(4'h8, 32'h0, CCR_RESP_SLVERR);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc(CCR_OFF_CTRL, 32'h04, OK);
      $display("sync test done");
   endtask : t_sync
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (5000) @(posedge aclk);
      n_errors++;
      report_and_stop();
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, dir} = 7'h0;
      {awaddr, araddr, wdata, vp, vn} = '0;
      wstrb = 4'hF;
      vn = 8'h40;
      n_errors = 0;
      checks = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_polarity();
      t_pin();
      t_sync();
      report_and_stop();
   end
endmodule : tb
